// ===== logic/odc_pkg.sv
// Package for the oscillator and divider control register block
`default_nettype none
package odc_pkg;
  // Register indices, word addressed
  localparam logic [1:0]  ADDR_OSC_CTRL   = 2'h0;
  localparam logic [1:0]  ADDR_CLK_DIV    = 2'h1;
  localparam logic [1:0]  ADDR_PLL_FB     = 2'h2;
  localparam logic [1:0]  ADDR_RC_TUNE    = 2'h3;
  // Unlock key words, written in order to the unlock address
  localparam logic [2:0]  ADDR_UNLOCK     = 3'h4;
  localparam logic [15:0] UNLOCK_KEY1     = 16'h0046;
  localparam logic [15:0] UNLOCK_KEY2     = 16'h0057;
  // Oscillator control fields
  localparam int          OC_SWREQ_BIT    = 0;
  localparam int          OC_SOSC_BIT     = 1;
  localparam int          OC_FAIL_BIT     = 3;
  localparam int          OC_NEW_LSB      = 8;
  localparam int          OC_CUR_LSB      = 12;
  // Clock divisor fields
  localparam int          CD_PRE_LSB      = 0;
  localparam int          CD_POST_LSB     = 6;
  localparam int          CD_FRC_LSB      = 8;
  localparam int          CD_RATIO_A_ENABLE_BIT    = 11;
  localparam int          CD_RATIO_A_LSB     = 12;
  localparam int          CD_ROI_BIT      = 15;
  // Reset values, and the reserved postscaler code
  localparam logic [2:0]  RATIO_A_RST        = 3'h3;
  localparam logic [2:0]  FRC_DIV_RST     = 3'h0;
  localparam logic [1:0]  POST_RST        = 2'h1;
  localparam logic [4:0]  PRE_RST         = 5'h00;
  localparam logic [8:0]  MULT_RST        = 9'h030;
  localparam logic [5:0]  TRIM_RST        = 6'h00;
  localparam logic [1:0]  POST_RESERVED   = 2'h2;
  // Cycles the switch takes to complete once the new source is ready
  localparam logic [3:0]  SWITCH_CYCLES   = 4'hA;

  typedef enum logic [2:0] {
    SRC_FRC      = 3'b000,
    SRC_FRC_PLL  = 3'b001,
    SRC_PRI      = 3'b010,
    SRC_PRI_PLL  = 3'b011,
    SRC_SEC      = 3'b100,
    SRC_LOW_POWER_RC_OSCILLATOR     = 3'b101,
    SRC_FRC_16   = 3'b110,
    SRC_FRC_N    = 3'b111
  } odc_src_t;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } odc_bus_req_t;

  // Clock settings steering the generator
  typedef struct packed {
    logic [9:0] fb_mult;      // Multiplier M, needs ten bits to reach 513
    logic [5:0] pre_div;      // Divider N1
    logic [3:0] post_div;     // Divider N2
    logic [8:0] frc_div;      // Fast RC divide
    logic [7:0] ratio_a_div;     // Processor to peripheral ratio
    logic [5:0] fast_rc_trim;
  } odc_clk_cfg_t;
endpackage
`default_nettype wire

// ===== logic/odc_regs.sv
// Oscillator control, clock divisor, PLL feedback and fast RC tuning registers
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module odc_regs
  import odc_pkg::*;
(
  // Clock and resets
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         sys_reset,
  // Register port
  input  wire odc_bus_req_t bus,
  output logic [15:0]       rdata,
  // Configuration and events
  input  wire logic         switch_enabled,
  input  wire logic [2:0]   reset_source,
  input  wire logic         clock_fail_event,
  input  wire logic         interrupt_event,
  input  wire logic         source_ready,
  // Clock generator controls
  output logic              secondary_osc_enable,
  output logic              switch_active,
  output logic [2:0]        current_source,
  output odc_clk_cfg_t      clk_cfg
);

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT = 2'b01,
    SW_SETL = 2'b10
  } odc_sw_state_t;

  logic [1:0]    unlock_q;
  logic          unlocked_q;
  logic          clock_fail_flag_q;
  logic          secondary_osc_enable_q;
  logic          switch_request_q;
  logic [2:0]    new_source_select_q;
  logic [2:0]    current_source_q;
  logic          recover_on_interrupt_q;
  logic [2:0]    ratio_a_q;
  logic          ratio_a_enable_q;
  logic [2:0]    fast_rc_postscaler_q;
  logic [1:0]    pll_postscaler_q;
  logic [4:0]    pll_prescaler_q;
  logic [8:0]    pll_multiplier_q;
  logic [5:0]    fast_rc_trim_q;
  logic          src_loaded_q;
  odc_sw_state_t sw_state_q;
  logic [3:0]    settle_q;
  logic [15:0]   rdata_q;
  odc_clk_cfg_t  cfg_q;
  logic          sw_active_q;

  logic wr_osc;
  logic wr_div;
  logic wr_fb;
  logic wr_tun;
  logic key_wr;
  logic sw_done;

  assign key_wr = bus.wr && (bus.addr == ADDR_UNLOCK);
  assign wr_osc = bus.wr && (bus.addr == {1'b0, ADDR_OSC_CTRL}) && unlocked_q;
  assign wr_div = bus.wr && (bus.addr == {1'b0, ADDR_CLK_DIV});
  assign wr_fb  = bus.wr && (bus.addr == {1'b0, ADDR_PLL_FB});
  assign wr_tun = bus.wr && (bus.addr == {1'b0, ADDR_RC_TUNE});
  assign sw_done = (sw_state_q == SW_SETL) && (settle_q == 4'h0);

  // Two key writes open a window for exactly one control write; any other write closes it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unlock_q   <= 2'h0;
      unlocked_q <= 1'b0;
    end else if (sys_reset) begin
      unlock_q   <= 2'h0;
      unlocked_q <= 1'b0;
    end else if (bus.wr) begin
      unlock_q   <= 2'h0;
      unlocked_q <= 1'b0;
      if (key_wr && bus.wdata == UNLOCK_KEY1) begin
        unlock_q <= 2'h1;
      end else if (key_wr && bus.wdata == UNLOCK_KEY2 && unlock_q == 2'h1) begin
        unlocked_q <= 1'b1;
      end
    end
  end

  // Clock-fail flag: set wins over a software clear; writing 1 does nothing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clock_fail_flag_q <= 1'b0;
    end else if (clock_fail_event) begin
      clock_fail_flag_q <= 1'b1;
    end else if (wr_osc && !bus.wdata[OC_FAIL_BIT]) begin
      clock_fail_flag_q <= 1'b0;
    end else if (sw_state_q == SW_IDLE && switch_request_q && new_source_select_q != current_source_q) begin
      clock_fail_flag_q <= 1'b0;
    end
  end

  // Power-on reset only; system resets leave these fields alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secondary_osc_enable_q <= 1'b0;
      new_source_select_q    <= SRC_FRC;
    end else if (wr_osc) begin
      secondary_osc_enable_q <= bus.wdata[OC_SOSC_BIT];
      new_source_select_q    <= bus.wdata[OC_NEW_LSB +: 3];
    end
  end

  // Current source is taken from the reset source at the first edge after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      current_source_q <= SRC_FRC;
      src_loaded_q     <= 1'b0;
    end else if (!src_loaded_q) begin
      current_source_q <= reset_source;
      src_loaded_q     <= 1'b1;
    end else if (sw_done) begin
      current_source_q <= new_source_select_q;
    end
  end

  // Switch request and its sequence
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      switch_request_q <= 1'b0;
      sw_state_q       <= SW_IDLE;
      settle_q         <= 4'h0;
    end else if (!switch_enabled) begin
      switch_request_q <= 1'b0;
      sw_state_q       <= SW_IDLE;
      settle_q         <= 4'h0;
    end else begin
      unique case (sw_state_q)
        SW_IDLE: begin
          if (wr_osc && bus.wdata[OC_SWREQ_BIT]) begin
            switch_request_q <= 1'b1;
          end else if (switch_request_q) begin
            if (new_source_select_q == current_source_q) begin
              switch_request_q <= 1'b0;
            end else begin
              sw_state_q <= SW_WAIT;
            end
          end
        end
        SW_WAIT: begin
          if (source_ready) begin
            sw_state_q <= SW_SETL;
            settle_q   <= SWITCH_CYCLES - 4'h1;
          end
        end
        SW_SETL: begin
          if (settle_q == 4'h0) begin
            switch_request_q <= 1'b0;
            sw_state_q       <= SW_IDLE;
          end else begin
            settle_q <= settle_q - 4'h1;
          end
        end
        default: begin
          sw_state_q <= SW_IDLE;
        end
      endcase
    end
  end

  // Clock divisor; interrupt recovery overrides a same-cycle write of ratio_a enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      recover_on_interrupt_q <= 1'b0;
      ratio_a_q              <= RATIO_A_RST;
      ratio_a_enable_q          <= 1'b0;
      fast_rc_postscaler_q   <= FRC_DIV_RST;
      pll_postscaler_q       <= POST_RST;
      pll_prescaler_q        <= PRE_RST;
    end else begin
      if (wr_div) begin
        recover_on_interrupt_q <= bus.wdata[CD_ROI_BIT];
        ratio_a_q              <= bus.wdata[CD_RATIO_A_LSB +: 3];
        fast_rc_postscaler_q   <= bus.wdata[CD_FRC_LSB +: 3];
        pll_postscaler_q       <= bus.wdata[CD_POST_LSB +: 2];
        pll_prescaler_q        <= bus.wdata[CD_PRE_LSB +: 5];
      end
      if (interrupt_event && recover_on_interrupt_q) begin
        ratio_a_enable_q <= 1'b0;
      end else if (wr_div) begin
        ratio_a_enable_q <= bus.wdata[CD_RATIO_A_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_multiplier_q <= MULT_RST;
      fast_rc_trim_q   <= TRIM_RST;
    end else begin
      if (wr_fb) begin
        pll_multiplier_q <= bus.wdata[8:0];
      end
      if (wr_tun) begin
        fast_rc_trim_q <= bus.wdata[5:0];
      end
    end
  end

  // Effective divide settings, registered so the generator sees clean values
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= '0;
    end else begin
      cfg_q.fb_mult  <= {1'b0, pll_multiplier_q} + 10'h002;
      cfg_q.pre_div  <= {1'b0, pll_prescaler_q} + 6'h02;
      unique case (pll_postscaler_q)
        2'h0:          cfg_q.post_div <= 4'h2;
        2'h1:          cfg_q.post_div <= 4'h4;
        POST_RESERVED: cfg_q.post_div <= 4'h4;
        2'h3:          cfg_q.post_div <= 4'h8;
      endcase
      if (fast_rc_postscaler_q == 3'h7) begin
        cfg_q.frc_div <= 9'h100;
      end else begin
        cfg_q.frc_div <= 9'h001 << fast_rc_postscaler_q;
      end
      cfg_q.ratio_a_div     <= ratio_a_enable_q ? (8'h01 << ratio_a_q) : 8'h01;
      cfg_q.fast_rc_trim <= fast_rc_trim_q;
    end
  end

  // Read data one cycle after the strobe; unimplemented bits read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        {1'b0, ADDR_OSC_CTRL}: rdata_q <= {1'b0, current_source_q, 1'b0, new_source_select_q, 4'h0,
                                           clock_fail_flag_q, 1'b0, secondary_osc_enable_q,
                                           (switch_request_q & switch_enabled)};
        {1'b0, ADDR_CLK_DIV}:  rdata_q <= {recover_on_interrupt_q, ratio_a_q, ratio_a_enable_q,
                                           fast_rc_postscaler_q, pll_postscaler_q, 1'b0, pll_prescaler_q};
        {1'b0, ADDR_PLL_FB}:   rdata_q <= {7'h00, pll_multiplier_q};
        {1'b0, ADDR_RC_TUNE}:  rdata_q <= {10'h000, fast_rc_trim_q};
        default:               rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw_active_q <= 1'b0;
    end else begin
      sw_active_q <= (sw_state_q != SW_IDLE) && !sw_done;
    end
  end

  assign rdata                = rdata_q;
  assign secondary_osc_enable = secondary_osc_enable_q;
  assign switch_active        = sw_active_q;
  assign current_source       = current_source_q;
  assign clk_cfg              = cfg_q;

endmodule // odc_regs
`default_nettype wire

// ===== dv/odc_regs_sva.sv
// Assertion checker for the oscillator and divider control registers
`timescale 1ns/1ps
`default_nettype none
module odc_regs_sva
  import odc_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         rstn,
  // Register port
  input wire odc_bus_req_t bus,
  input wire logic [15:0]  rdata,
  // Switch control and outputs
  input wire logic         switch_enabled,
  input wire logic         source_ready,
  input wire logic         secondary_osc_enable,
  input wire logic         switch_active,
  input wire logic [2:0]   current_source,
  input wire odc_clk_cfg_t clk_cfg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  function automatic logic [15:0] zmask(input logic [2:0] a);
    case (a)
      3'h0: return 16'h88F4;
      3'h1: return 16'h0020;
      3'h2: return 16'hFE00;
      3'h3: return 16'hFFC0;
      default: return 16'hFFFF;
    endcase
  endfunction

  function automatic logic [3:0] post_n(input logic [1:0] c);
    return (c == 2'h3) ? 4'h8 : ((c == 2'h0) ? 4'h2 : 4'h4);
  endfunction

  sequence div_wr_s;
    bus.wr && bus.addr == 3'h1;
  endsequence
  sequence settle_s;
    switch_active [*8] ##1 switch_active;
  endsequence

  unimpl_zero_a: assert property ($past(bus.rd) |-> (rdata & zmask($past(bus.addr))) == 16'h0000)
    else $error("unimplemented bit read as one");
  cur_read_a: assert property ($past(bus.rd && bus.addr == 3'h0) |->
    rdata[14:12] == $past(current_source))
    else $error("current source field differs from port");
  no_switch_a: assert property ($past(bus.rd && bus.addr == 3'h0 && !switch_enabled) |-> !rdata[0])
    else $error("switch request set while switching disabled");
  src_change_a: assert property ($changed(current_source) && $past(rstn, 2) |-> $past(switch_active))
    else $error("current source changed outside a switch");
  settle_a: assert property ($rose(source_ready) && switch_active |=> settle_s)
    else $error("switch ended before settling");
  settle_end_a: assert property ($rose(source_ready) && switch_active |-> ##[9:16] !switch_active)
    else $error("switch did not complete");
  sec_en_a: assert property ($changed(secondary_osc_enable) |-> $past(bus.wr && bus.addr == 3'h0))
    else $error("secondary enable changed without a write");
  pre_cfg_a: assert property (div_wr_s |-> ##2 clk_cfg.pre_div == 6'($past(bus.wdata[4:0], 2)) + 6'h02)
    else $error("prescaler divide wrong");
  post_cfg_a: assert property (div_wr_s |->
    ##2 clk_cfg.post_div == post_n($past(bus.wdata[7:6], 2)))
    else $error("postscaler divide wrong");
  ratio_a_off_a: assert property (div_wr_s ##0 !bus.wdata[11] |-> ##2 clk_cfg.ratio_a_div == 8'h01)
    else $error("ratio not 1:1 with ratio_a off");
  mult_cfg_a: assert property (bus.wr && bus.addr == 3'h2 |->
    ##2 clk_cfg.fb_mult == {1'b0, $past(bus.wdata[8:0], 2)} + 10'h002)
    else $error("feedback multiplier wrong");
endmodule // odc_regs_sva

bind odc_regs odc_regs_sva u_odc_regs_sva (
  .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .switch_enabled(switch_enabled),
  .source_ready(source_ready), .secondary_osc_enable(secondary_osc_enable), .switch_active(switch_active),
  .current_source(current_source), .clk_cfg(clk_cfg));
`default_nettype wire

// ===== dv/test_odc_regs.sv
// Self-checking bench for the oscillator and divider control registers
`timescale 1ns/1ps
`default_nettype none
module test_odc_regs
  import odc_pkg::*;
;
  logic         clk;
  logic         rstn;
  logic         sys_reset;
  odc_bus_req_t bus;
  logic [15:0]  rdata;
  logic         sw_en;
  logic         fail_ev;
  logic         irq_ev;
  logic         src_rdy;
  logic         sec_en;
  logic         sw_act;
  logic [2:0]   cur_src;
  odc_clk_cfg_t cfg;
  int           errors;
  int           total_checks;
  int           cyc;
  int           k;

  always #12.5 clk = ~clk;

  odc_regs uut (.clk(clk), .rstn(rstn), .sys_reset(sys_reset), .bus(bus), .rdata(rdata),
    .switch_enabled(sw_en), .reset_source(3'h0), .clock_fail_event(fail_ev), .interrupt_event(irq_ev),
    .source_ready(src_rdy), .secondary_osc_enable(sec_en), .switch_active(sw_act),
    .current_source(cur_src), .clk_cfg(cfg));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Every bus task starts on its own edge, so strobes never get two drives in one step
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic ulw(input logic [15:0] d);
    wr(3'h4, UNLOCK_KEY1);
    wr(3'h4, UNLOCK_KEY2);
    wr(3'h0, d);
  endtask

  task automatic kick(input logic [1:0] m);
    @(posedge clk);
    {irq_ev, fail_ev} <= m;
    @(posedge clk);
    {irq_ev, fail_ev} <= 2'b00;
  endtask

  task automatic t_reset;
    rd(3'h0, 16'h0000);
    rd(3'h1, 16'h3040);
    rd(3'h2, 16'h0030);
    rd(3'h3, 16'h0000);
    rd(3'h5, 16'h0000);
    chk({6'h00, cfg.fb_mult}, 16'h0032);
    chk({12'h000, cfg.post_div}, 16'h0004);
    chk({7'h00, cfg.frc_div}, 16'h0001);
    $display("reset values done");
  endtask

  task automatic t_fields;
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, 3'(i), 1'b1, 3'(i), 2'(i), 1'b0, 5'(i * 4 + 3)};
      wr(3'h1, v);
      rd(3'h1, v);
      chk({7'h00, cfg.frc_div}, (i == 7) ? 16'h0100 : 16'h0001 << i);
      chk({8'h00, cfg.ratio_a_div}, 16'h0001 << i);
      chk({10'h000, cfg.pre_div}, 16'(i * 4 + 5));
      chk({12'h000, cfg.post_div}, (i % 4 == 3) ? 16'h8 : ((i % 4 == 0) ? 16'h2 : 16'h4));
    end
    wr(3'h2, 16'hFE3F);
    rd(3'h2, 16'h003F);
    chk({6'h00, cfg.fb_mult}, 16'h0041);
    wr(3'h2, 16'h01FF);
    rd(3'h2, 16'h01FF);
    chk({6'h00, cfg.fb_mult}, 16'h0201);
    wr(3'h3, 16'hFFE0);
    rd(3'h3, 16'h0020);
    chk({10'h000, cfg.fast_rc_trim}, 16'h0020);
    $display("field decode done");
  endtask

  task automatic t_lock;
    wr(3'h0, 16'h0002);
    rd(3'h0, 16'h0000);
    ulw(16'h0002);
    rd(3'h0, 16'h0002);
    chk({15'h0000, sec_en}, 16'h0001);
    @(posedge clk);
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
    rd(3'h0, 16'h0002);
    rd(3'h3, 16'h0020);
    $display("unlock done");
  endtask

  task automatic t_fail;
    kick(2'b01);
    rd(3'h0, 16'h000A);
    ulw(16'h0002);
    rd(3'h0, 16'h0002);
    ulw(16'h000A);
    rd(3'h0, 16'h0002);
    $display("clock fail done");
  endtask

  task automatic t_switch;
    ulw(16'h0203);
    rd(3'h0, 16'h0203);
    for (k = 0; k < 8 && sw_act !== 1'b1; k++) @(posedge clk);
    chk({15'h0000, sw_act}, 16'h0001);
    @(posedge clk);
    src_rdy <= 1'b1;
    for (k = 0; k < 30 && sw_act !== 1'b0; k++) @(negedge clk);
    rd(3'h0, 16'h2202);
    ulw(16'h0203);
    @(posedge clk);
    rd(3'h0, 16'h2202);
    chk({15'h0000, sw_act}, 16'h0000);
    @(posedge clk);
    sw_en <= 1'b0;
    ulw(16'h0003);
    rd(3'h0, 16'h2002);
    chk({13'h0000, cur_src}, 16'h0002);
    @(posedge clk);
    sw_en <= 1'b1;
    src_rdy <= 1'b0;
    $display("switch done");
  endtask

  task automatic t_roi;
    wr(3'h1, 16'hB800);
    kick(2'b10);
    rd(3'h1, 16'hB000);
    chk({8'h00, cfg.ratio_a_div}, 16'h0001);
    wr(3'h1, 16'h3800);
    kick(2'b10);
    rd(3'h1, 16'h3800);
    chk({8'h00, cfg.ratio_a_div}, 16'h0008);
    $display("recover on interrupt done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    sys_reset = 1'b0;
    bus = '0;
    sw_en = 1'b1;
    fail_ev = 1'b0;
    irq_ev = 1'b0;
    src_rdy = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_fields();
    t_lock();
    t_fail();
    t_switch();
    t_roi();
    test_done();
  end
endmodule // test_odc_regs
`default_nettype wire
